// ### verilog/adc_ctl_regs.svh
// Register map, field positions and timing counts of the converter sequencer
//
// Contract
// - Clock select bits 7:6: 00 div2, 01 div8, 10 div32, 11 internal RC clock.
// - Channel select bits 5:3 route analog input numbered by the field value.
// - Writing go bit 2 while powered starts conversion; reads 1; hardware clears it.
// - Control bit 1 always reads zero whatever is written.
// - Power-on bit 0 powers the converter; cleared means shut down.
// - Result format 1 right justifies, 0 left justifies, unused six bits zero.
// - Pin config bits 3:0 decode each pin role and both reference sources.
// - Pin config 0000 all analog with supply references; 011x all digital.
// - Some codes take input 3 as positive, input 2 as negative reference.
// - Any reset forces every shared pin to analog input.
// - Completion loads the 10-bit result, clears go, sets done together; a go write with power on in the same cycle keeps go set.
// - A conversion takes 12 bit periods from go to result.
// - Clearing go mid conversion aborts, keeps result, reacquires after two periods.
// - After completion the hold stays disconnected for two bit periods.
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH

`define ADC_ADDR_W        3
`define ADC_CONTROL_ADDR  3'h0
`define ADC_PORTCFG_ADDR  3'h1
`define ADC_RES_HIGH_ADDR 3'h2
`define ADC_RES_LOW_ADDR  3'h3
`define ADC_STATUS_ADDR   3'h4

`define ADC_CONTROL_RST   8'h00
`define ADC_PORTCFG_RST   8'h00
`define ADC_CLKSEL_HI     7
`define ADC_CLKSEL_LO     6
`define ADC_CHAN_HI       5
`define ADC_CHAN_LO       3
`define ADC_GO_BIT        2
`define ADC_POWER_BIT     0
`define ADC_FORMAT_BIT    5
`define ADC_PCFG_HI       3
`define ADC_PCFG_LO       0
`define ADC_DONE_BIT      0

`define ADC_DIV_SLOW      6'h1f
`define ADC_DIV_MID       6'h07
`define ADC_DIV_FAST      6'h01
`define ADC_CONV_LAST     4'hb
`define ADC_DISCH_LAST    4'h1
`define ADC_SAR_LAST      4'ha

`endif

// ### verilog/adc_ctl_pkg.sv
// Types shared by the converter sequencer files
package adc_ctl_pkg;

    typedef enum logic [1:0] {
        ADC_CLK_DIV2  = 2'h0,
        ADC_CLK_DIV8  = 2'h1,
        ADC_CLK_DIV32 = 2'h2,
        ADC_CLK_RC    = 2'h3
    } adc_clksel_t;

    typedef enum logic [3:0] {
        ADC_ST_OFF   = 4'b0001,
        ADC_ST_ACQ   = 4'b0010,
        ADC_ST_CONV  = 4'b0100,
        ADC_ST_DISCH = 4'b1000
    } adc_state_t;

    typedef struct packed {
        adc_clksel_t clkSel;
        logic [2:0]  chanSel;
        logic        goFlag;
        logic        powerOn;
    } adc_ctrl_t;

    typedef struct packed {
        logic       resultFormat;
        logic [3:0] pinConfig;
    } adc_portcfg_t;

endpackage

// ### verilog/adc_tad_tick.sv
// Bit-period tick generator for the converter sequencer
`timescale 1ns/10ps
`include "adc_ctl_regs.svh"
module adc_tad_tick
    import adc_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  adc_clksel_t      clkSel,
    input  wire logic        rcEdge,
    input  wire logic        run,
    output logic             tick_ff
);

    logic [5:0] divCnt_ff;
    logic [5:0] divLast;

    always_comb
    begin
        case (clkSel)
            ADC_CLK_DIV2:  divLast = `ADC_DIV_FAST;
            ADC_CLK_DIV8:  divLast = `ADC_DIV_MID;
            ADC_CLK_DIV32: divLast = `ADC_DIV_SLOW;
            default:       divLast = `ADC_DIV_FAST;
        endcase
    end

    // Divider restarts when stopped so the first period is whole
    always_ff @(posedge clk)
    begin
        if (rst || !run || divCnt_ff >= divLast)
            divCnt_ff <= 6'h00;
        else
            divCnt_ff <= divCnt_ff + 6'h01;
    end

    always_ff @(posedge clk)
    begin
        if (rst || !run)
            tick_ff <= 1'b0;
        else if (clkSel == ADC_CLK_RC)
            tick_ff <= rcEdge;
        else
            tick_ff <= (divCnt_ff == divLast);
    end

endmodule

// ### verilog/adc_ctl_top.sv
// Converter control sequencer: registers, pin decode and conversion state machine
`timescale 1ns/10ps
`include "adc_ctl_regs.svh"
module adc_ctl_top
    import adc_ctl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [`ADC_ADDR_W-1:0] regAddr,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic [7:0]                 regRdData_ff,
    input  wire logic                  rcClkIn,
    input  wire logic                  cmpHigh,
    output logic [9:0]                 sarTrial_ff,
    output logic [2:0]                 chanSel_ff,
    output logic                       holdConnect_ff,
    output logic                       powerUp_ff,
    output logic [7:0]                 pinAnalog_ff,
    output logic                       vrefPosExt_ff,
    output logic                       vrefNegExt_ff,
    output logic                       doneFlag_ff
);

    //--------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------
    adc_ctrl_t    ctrl_ff;
    adc_portcfg_t pcfg_ff;
    adc_state_t   state_ff;
    adc_state_t   nxt_state;
    logic [9:0]   result_ff;
    logic [9:0]   nxt_sar;
    logic [3:0]   tadCnt_ff;
    logic [3:0]   bitIdx;
    logic [2:0]   rcSync_ff;
    logic         rcEdge;
    logic         tick;
    logic         wrCtrl;
    logic         wrPcfg;
    logic         wrStat;
    logic         goSet;
    logic         goClr;
    logic         complete;
    logic         abort;
    logic [7:0]   rdMux;
    logic [7:0]   decAnalog;
    logic         decPos;
    logic         decNeg;
    logic [3:0]   convTicks_ff;
    localparam logic [7:0] CTRL_RST_VAL = `ADC_CONTROL_RST;
    localparam logic [7:0] PCFG_RST_VAL = `ADC_PORTCFG_RST;

    assign wrCtrl = regWr && (regAddr == `ADC_CONTROL_ADDR);
    assign wrPcfg = regWr && (regAddr == `ADC_PORTCFG_ADDR);
    assign wrStat = regWr && (regAddr == `ADC_STATUS_ADDR);

    //--------------------------------------------------------------
    // Internal RC clock sync and edge detect
    //--------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            rcSync_ff <= 3'h0;
        else
            rcSync_ff <= {rcSync_ff[1:0], rcClkIn};
    end

    assign rcEdge = rcSync_ff[1] && !rcSync_ff[2];

    adc_tad_tick u_tick (
        .clk     (clk),
        .rst     (rst),
        .clkSel  (ctrl_ff.clkSel),
        .rcEdge  (rcEdge),
        .run     (ctrl_ff.powerOn),
        .tick_ff (tick)
    );

    //--------------------------------------------------------------
    // Conversion events
    //--------------------------------------------------------------
    // Go accepted only when the same write keeps power on
    assign goSet    = wrCtrl && regWrData[`ADC_GO_BIT] && regWrData[`ADC_POWER_BIT];
    assign goClr    = wrCtrl && !regWrData[`ADC_GO_BIT];
    assign complete = (state_ff == ADC_ST_CONV) && tick && (tadCnt_ff == `ADC_CONV_LAST)
                      && ctrl_ff.goFlag && !goClr;
    assign abort    = (state_ff == ADC_ST_CONV) && (goClr || !ctrl_ff.goFlag);

    //--------------------------------------------------------------
    // Control register
    //--------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_ff <= adc_ctrl_t'({CTRL_RST_VAL[7:2], CTRL_RST_VAL[0]});
        end
        else
        begin
            if (wrCtrl)
            begin
                ctrl_ff.clkSel  <= adc_clksel_t'(regWrData[`ADC_CLKSEL_HI:`ADC_CLKSEL_LO]);
                ctrl_ff.chanSel <= regWrData[`ADC_CHAN_HI:`ADC_CHAN_LO];
                ctrl_ff.powerOn <= regWrData[`ADC_POWER_BIT];
            end
            if (goSet)
                ctrl_ff.goFlag <= 1'b1;
            else if (goClr || complete || (wrCtrl && !regWrData[`ADC_POWER_BIT]))
                ctrl_ff.goFlag <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Port configuration register
    //--------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            pcfg_ff <= adc_portcfg_t'({PCFG_RST_VAL[5], PCFG_RST_VAL[3:0]});
        else if (wrPcfg)
        begin
            pcfg_ff.resultFormat <= regWrData[`ADC_FORMAT_BIT];
            pcfg_ff.pinConfig    <= regWrData[`ADC_PCFG_HI:`ADC_PCFG_LO];
        end
    end

    //--------------------------------------------------------------
    // Pin role and reference decode
    //--------------------------------------------------------------
    always_comb
    begin
        decPos = 1'b0;
        decNeg = 1'b0;
        case (pcfg_ff.pinConfig)
            4'h0:    decAnalog = 8'hff;
            4'h1:    begin decAnalog = 8'hf7; decPos = 1'b1; end
            4'h2:    decAnalog = 8'h1f;
            4'h3:    begin decAnalog = 8'h17; decPos = 1'b1; end
            4'h4:    decAnalog = 8'h0b;
            4'h5:    begin decAnalog = 8'h03; decPos = 1'b1; end
            4'h6:    decAnalog = 8'h00;
            4'h7:    decAnalog = 8'h00;
            4'h8:    begin decAnalog = 8'hf3; decPos = 1'b1; decNeg = 1'b1; end
            4'h9:    decAnalog = 8'h3f;
            4'ha:    begin decAnalog = 8'h37; decPos = 1'b1; end
            4'hb:    begin decAnalog = 8'h33; decPos = 1'b1; decNeg = 1'b1; end
            4'hc:    begin decAnalog = 8'h13; decPos = 1'b1; decNeg = 1'b1; end
            4'hd:    begin decAnalog = 8'h03; decPos = 1'b1; decNeg = 1'b1; end
            4'he:    decAnalog = 8'h01;
            default: begin decAnalog = 8'h01; decPos = 1'b1; decNeg = 1'b1; end
        endcase
    end

    // Reset forces all shared pins analog
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pinAnalog_ff  <= 8'hff;
            vrefPosExt_ff <= 1'b0;
            vrefNegExt_ff <= 1'b0;
        end
        else
        begin
            pinAnalog_ff  <= decAnalog;
            vrefPosExt_ff <= decPos;
            vrefNegExt_ff <= decNeg;
        end
    end

    //--------------------------------------------------------------
    // Conversion state machine
    //--------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ADC_ST_OFF:   if (ctrl_ff.powerOn) nxt_state = ADC_ST_ACQ;
            ADC_ST_ACQ:   if (ctrl_ff.goFlag) nxt_state = ADC_ST_CONV;
            ADC_ST_CONV:  if (complete || abort) nxt_state = ADC_ST_DISCH;
            ADC_ST_DISCH: if (tick && tadCnt_ff == `ADC_DISCH_LAST)
                              nxt_state = ADC_ST_ACQ;
            default:      nxt_state = ADC_ST_OFF;
        endcase
        if (!ctrl_ff.powerOn)
            nxt_state = ADC_ST_OFF;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state_ff <= ADC_ST_OFF;
        else
            state_ff <= nxt_state;
    end

    // Bit periods elapsed in the current phase
    always_ff @(posedge clk)
    begin
        if (rst || nxt_state != state_ff)
            tadCnt_ff <= 4'h0;
        else if (tick)
            tadCnt_ff <= tadCnt_ff + 4'h1;
    end

    //--------------------------------------------------------------
    // Successive approximation
    //--------------------------------------------------------------
    assign bitIdx = `ADC_SAR_LAST - tadCnt_ff;

    always_comb
    begin
        nxt_sar = sarTrial_ff;
        if (tadCnt_ff == 4'h0)
            nxt_sar = 10'h200;
        else if (tadCnt_ff <= `ADC_SAR_LAST)
        begin
            if (!cmpHigh)
                nxt_sar[bitIdx] = 1'b0;
            if (bitIdx != 4'h0)
                nxt_sar[bitIdx - 4'h1] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            sarTrial_ff <= 10'h000;
        else if (state_ff == ADC_ST_CONV && tick)
            sarTrial_ff <= nxt_sar;
    end

    // Abort leaves the previous result in place
    always_ff @(posedge clk)
    begin
        if (rst)
            result_ff <= 10'h000;
        else if (complete)
            result_ff <= sarTrial_ff;
    end

    // Done flag: a completion wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            doneFlag_ff <= 1'b0;
        else if (complete)
            doneFlag_ff <= 1'b1;
        else if (wrStat && regWrData[`ADC_DONE_BIT])
            doneFlag_ff <= 1'b0;
    end

    //--------------------------------------------------------------
    // Analog front end controls
    //--------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            holdConnect_ff <= 1'b0;
            chanSel_ff     <= 3'h0;
            powerUp_ff     <= 1'b0;
        end
        else
        begin
            // Hold stays connected through the first period of a conversion and opens at its first tick
            holdConnect_ff <= (nxt_state == ADC_ST_ACQ) ||
                              (nxt_state == ADC_ST_CONV && state_ff == ADC_ST_ACQ) ||
                              (nxt_state == ADC_ST_CONV && tadCnt_ff == 4'h0 && !tick);
            chanSel_ff     <= ctrl_ff.chanSel;
            powerUp_ff     <= ctrl_ff.powerOn;
        end
    end

    //--------------------------------------------------------------
    // Register read
    //--------------------------------------------------------------
    always_comb
    begin
        case (regAddr)
            `ADC_CONTROL_ADDR:  rdMux = {ctrl_ff.clkSel, ctrl_ff.chanSel, ctrl_ff.goFlag,
                                         1'b0, ctrl_ff.powerOn};
            `ADC_PORTCFG_ADDR:  rdMux = {2'h0, pcfg_ff.resultFormat, 1'b0, pcfg_ff.pinConfig};
            `ADC_RES_HIGH_ADDR: rdMux = pcfg_ff.resultFormat ? {6'h00, result_ff[9:8]}
                                                             : result_ff[9:2];
            `ADC_RES_LOW_ADDR:  rdMux = pcfg_ff.resultFormat ? result_ff[7:0]
                                                             : {result_ff[1:0], 6'h00};
            `ADC_STATUS_ADDR:   rdMux = {7'h00, doneFlag_ff};
            default:            rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst || !regRd)
            regRdData_ff <= 8'h00;
        else
            regRdData_ff <= rdMux;
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    always_ff @(posedge clk)
        convTicks_ff <= (rst || state_ff != ADC_ST_CONV) ? 4'h0 : convTicks_ff + {3'h0, tick};

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_done_on_complete: assert property (complete |=> doneFlag_ff && !ctrl_ff.goFlag)
        else $error("completion did not set done and clear go");
    a_result_loaded: assert property (complete |=> result_ff == $past(sarTrial_ff))
        else $error("result not loaded at completion");
    a_conv_length: assert property (complete |-> convTicks_ff == 4'hb && tick)
        else $error("conversion did not last twelve bit periods");
    a_abort_keeps: assert property (abort |=> $stable(result_ff)[*3])
        else $error("abort changed the result");
    a_disch_hold: assert property (state_ff == ADC_ST_DISCH |-> !holdConnect_ff)
        else $error("hold reconnected during discharge");
    a_off_no_go: assert property (wrCtrl && !regWrData[0] |=> !ctrl_ff.goFlag)
        else $error("go set while powered off");
    a_bit1_zero: assert property (regRd && regAddr == 3'h0 |=> regRdData_ff[1] == 1'b0)
        else $error("control bit 1 read nonzero");
    a_right_fmt: assert property (regRd && regAddr == 3'h2 && pcfg_ff.resultFormat
                                  |=> regRdData_ff[7:2] == 6'h00)
        else $error("right justified high byte not zero on top");
    a_left_fmt: assert property (regRd && regAddr == 3'h3 && !pcfg_ff.resultFormat
                                 |=> regRdData_ff[5:0] == 6'h00)
        else $error("left justified low byte not zero on bottom");
    a_all_digital: assert property (pcfg_ff.pinConfig[3:1] == 3'h3 |=> pinAnalog_ff == 8'h00)
        else $error("all digital code left analog pins");

    c_complete: cover property (complete);
    c_abort: cover property (abort);
    c_right_read: cover property (regRd && regAddr == 3'h2 && pcfg_ff.resultFormat);

endmodule

// ### tb/adc_ctl_tb_top.sv
// Self-checking bench for the converter control sequencer
`timescale 1ns/10ps
`include "adc_ctl_regs.svh"
`define CHECK(what, exp, got) \
    begin \
        checkCount++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("unexpected %s: expected %h, seen %h", what, exp, got); \
        end \
    end
module adc_ctl_tb_top;
    logic                    clk;
    logic                    rst;
    logic [`ADC_ADDR_W-1:0]  regAddr;
    logic [7:0]              regWrData;
    logic                    regWr;
    logic                    regRd;
    logic [7:0]              regRdData_ff;
    logic                    rcClkIn = 1'b0;
    logic                    cmpHigh;
    logic [9:0]              sarTrial_ff;
    logic [2:0]              chanSel_ff;
    logic                    holdConnect_ff;
    logic                    powerUp_ff;
    logic [7:0]              pinAnalog_ff;
    logic                    vrefPosExt_ff;
    logic                    vrefNegExt_ff;
    logic                    doneFlag_ff;
    logic [1:0]              rcCnt = 2'h0;
    int                      failures = 0;
    int                      checkCount = 0;
    logic [7:0]              expA [16] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00,
                                           8'h00, 8'hf3, 8'h3f, 8'h37, 8'h33, 8'h13, 8'h03,
                                           8'h01, 8'h01};
    logic [15:0]             vpTab = 16'hbd2a;
    logic [15:0]             vnTab = 16'hb900;

    adc_ctl_top i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff), .rcClkIn(rcClkIn),
        .cmpHigh(cmpHigh), .sarTrial_ff(sarTrial_ff), .chanSel_ff(chanSel_ff),
        .holdConnect_ff(holdConnect_ff), .powerUp_ff(powerUp_ff), .pinAnalog_ff(pinAnalog_ff),
        .vrefPosExt_ff(vrefPosExt_ff), .vrefNegExt_ff(vrefNegExt_ff), .doneFlag_ff(doneFlag_ff));

    // ---------------------------------------------------------------
    // Clock and internal RC source (period of six system clocks)
    // ---------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        rcCnt <= (rcCnt == 2'h2) ? 2'h0 : rcCnt + 2'h1;
        if (rcCnt == 2'h2)
            rcClkIn <= ~rcClkIn;
    end

    // ---------------------------------------------------------------
    // Register access and helpers
    // ---------------------------------------------------------------
    task automatic results;
        $display("checks %0d, mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWr     <= 1'b0;
    endtask

    task automatic rdChk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        `CHECK(what, exp, regRdData_ff)
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Counts cycles until the watched flag goes high, bounded
    task automatic waitHigh(input bit useDone, inout int n);
        while ((useDone ? doneFlag_ff : holdConnect_ff) !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > 2000)
            begin
                failures++;
                $display("unexpected timeout waiting for flag");
                results();
            end
        end
    endtask

    // One conversion per clock source; checks duration, hold gap and result views
    task automatic convert(input logic [1:0] cs);
        int         p;
        int         n;
        logic [9:0] r;
        p = (cs == 2'h0) ? 2 : (cs == 2'h1) ? 8 : (cs == 2'h2) ? 32 : 6;
        r = cs[0] ? 10'h3ff : 10'h000;
        cmpHigh <= cs[0];
        wr(3'h1, 8'h20);
        wr(3'h0, {cs, 3'h5, 3'b001});
        wr(3'h4, 8'h01);
        repeat (40) @(posedge clk);
        wr(3'h0, {cs, 3'h5, 3'b101});
        rdChk(3'h0, {cs, 3'h5, 3'b101}, "go while busy");
        n = 2;
        waitHigh(1'b1, n);
        `CHECK("conversion length", 1'b1, (n >= 11 * p + 1 && n <= 12 * p + 6))
        `CHECK("final trial", r, sarTrial_ff)
        `CHECK("hold after done", 1'b0, holdConnect_ff)
        n = 0;
        waitHigh(1'b0, n);
        `CHECK("hold gap", 1'b1, (n >= p && n <= 2 * p + 3))
        rdChk(3'h0, {cs, 3'h5, 3'b001}, "go cleared");
        rdChk(3'h4, 8'h01, "done status");
        rdChk(3'h2, {6'h00, r[9:8]}, "right high");
        rdChk(3'h3, r[7:0], "right low");
        wr(3'h1, 8'h00);
        rdChk(3'h2, r[9:2], "left high");
        rdChk(3'h3, {r[1:0], 6'h00}, "left low");
        wr(3'h4, 8'h01);
        settle();
        `CHECK("done cleared", 1'b0, doneFlag_ff)
        $display("test conversion source %0d done", cs);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        logic [3:0] c;
        int         n;
        rst = 1'b1;
        regAddr = '0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        cmpHigh = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHECK("pins at reset", 8'hff, pinAnalog_ff)
        rdChk(3'h0, 8'h00, "control reset");
        rdChk(3'h1, 8'h00, "port config reset");
        @(posedge clk);
        #1;
        `CHECK("read data after slot", 8'h00, regRdData_ff)
        wr(3'h5, 8'hff);
        rdChk(3'h5, 8'h00, "unmapped read");
        $display("test reset and map done");

        wr(3'h0, 8'hfe);
        repeat (60) @(posedge clk);
        rdChk(3'h0, 8'hf8, "control unpowered go");
        `CHECK("no done unpowered", 1'b0, doneFlag_ff)
        for (int i = 0; i < 8; i++)
        begin
            wr(3'h0, {2'h0, i[2:0], 3'b000});
            settle();
            `CHECK("channel", i[2:0], chanSel_ff)
        end
        $display("test control fields done");

        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            wr(3'h1, 8'hd0 | {2'h0, c[0], 5'h00} | {4'h0, c});
            settle();
            `CHECK("analog pins", expA[i], pinAnalog_ff)
            `CHECK("positive ref", vpTab[i], vrefPosExt_ff)
            `CHECK("negative ref", vnTab[i], vrefNegExt_ff)
            rdChk(3'h1, {2'h0, c[0], 1'b0, c}, "port config");
        end
        $display("test pin decode done");

        for (int i = 0; i < 4; i++)
            convert(i[1:0]);

        cmpHigh <= 1'b0;
        wr(3'h0, 8'h01);
        repeat (20) @(posedge clk);
        wr(3'h0, 8'h05);
        repeat (8) @(posedge clk);
        wr(3'h0, 8'h01);
        #1;
        n = 0;
        waitHigh(1'b0, n);
        `CHECK("reacquire after abort", 1'b1, (n >= 3 && n <= 4))
        settle();
        rdChk(3'h0, 8'h01, "go after abort");
        repeat (40) @(posedge clk);
        #1;
        `CHECK("no done on abort", 1'b0, doneFlag_ff)
        rdChk(3'h2, 8'hff, "kept high");
        rdChk(3'h3, 8'hc0, "kept low");
        wr(3'h0, 8'h00);
        settle();
        `CHECK("power off", 1'b0, powerUp_ff)
        wr(3'h0, 8'h01);
        settle();
        `CHECK("power on", 1'b1, powerUp_ff)
        $display("test abort and power done");

        wr(3'h1, 8'h06);
        settle();
        `CHECK("all digital", 8'h00, pinAnalog_ff)
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHECK("pins after reset", 8'hff, pinAnalog_ff)
        `CHECK("power after reset", 1'b0, powerUp_ff)
        rdChk(3'h1, 8'h00, "port config after reset");
        $display("test second reset done");
        results();
    end
endmodule
